//--- src/dtp_map.svh
// Touch-probe constants: control/status bit positions and object indices.
// Assumes inclusion by the probe latch module only.
`ifndef DTP_MAP_SVH
`define DTP_MAP_SVH
`define DTP_IDX_CTRL        16'h60b8
`define DTP_IDX_STAT        16'h60b9
`define DTP_IDX_P1_RISE     16'h60ba
`define DTP_IDX_P1_FALL     16'h60bb
`define DTP_IDX_P2_RISE     16'h60bc
`define DTP_IDX_P2_FALL     16'h60bd
// Per-probe field offsets within an 8-bit byte; probe two sits at +8
`define DTP_PROBE_STRIDE    8
`define DTP_PROBE_COUNT     2
`define DTP_C_ENABLE        0
`define DTP_C_CONTINUOUS    1
`define DTP_C_SOURCE        2
`define DTP_C_RISE_EN       4
`define DTP_C_FALL_EN       5
`define DTP_S_ENABLED       0
`define DTP_S_RISE_DONE     1
`define DTP_S_FALL_DONE     2
`define DTP_S_SOURCE        6
`define DTP_S_LEVEL         7
`define DTP_CTRL_RESET      16'h0000
`define DTP_STAT_RESET      16'h0000
`define DTP_POS_RESET       32'h0000_0000
`endif

//--- src/dtp_pkg.sv
// Touch-probe package: shared types for the dual probe latch.
// Assumes dtp_map.svh is on the include path.
package dtp_pkg;
   typedef struct packed {
      logic [31:0] rise;
      logic [31:0] fall;
   } dtp_capture_s;

   typedef struct packed {
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic       prev;
      logic       rise_done;
      logic       fall_done;
      logic       rise_armed;
      logic       fall_armed;
   } dtp_probe_s;

   typedef struct packed {
      logic [15:0]  ctrl_prev;
      logic [15:0]  status;
      dtp_probe_s   [1:0] probe;
      dtp_capture_s [1:0] cap;
   } dtp_state_s;
endpackage

//--- src/dtp_probe_latch.sv
// Function
// - Index source allows rising edge capture only; falling edge ignored.
// - Control bit 0 arms probe one; zero blocks probe one's rise and fall captures.
// - Control bit 1: zero single capture, one continuous capture.
// - Control bit 2: zero digital input four, one index pulse.
// - Control bit 4 enables rising edge position capture.
// - Control bit 5 enables falling edge position capture.
// - Bits 8 to 13 control probe two; bit 10 zero picks input five, one index pulse.
// - Status bits 0 and 8 show each probe enabled.
// - Status bits 1 and 9 set after a rising capture.
// - Status bits 2 and 10 set after a falling capture.
// - Layout zero: bits 6,14 echo source, bits 7,15 input level.
// - Layout select input chooses between the two word layouts.
// - Qualifying rising edge stores position command into rise register.
//
// Dual touch-probe edge latch, register words exchanged as process data.
// Assumes probe inputs and index pulse are asynchronous; position is local.
`timescale 1ns/1ps
`include "dtp_map.svh"

module dtp_probe_latch
   import dtp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] probe_control_word,
   input  wire logic        probe_layout_select,
   input  wire logic        digital_input_four,
   input  wire logic        digital_input_five,
   input  wire logic        encoder_index,
   input  wire logic [31:0] position_command,
   output logic      [15:0] probe_status_word,
   output logic      [31:0] probe_one_rise_capture,
   output logic      [31:0] probe_one_fall_capture,
   output logic      [31:0] probe_two_rise_capture,
   output logic      [31:0] probe_two_fall_capture
);

   dtp_state_s state;
   dtp_state_s next_state;
   logic [1:0] dig_in;

   assign dig_in = {digital_input_five, digital_input_four};

   always_comb begin
      logic [7:0] c;
      logic       en;
      logic       en_rise;
      logic       sig;
      logic       rise_edge;
      logic       fall_edge;
      integer     base;
      c         = 8'h00;
      en        = 1'b0;
      en_rise   = 1'b0;
      sig       = 1'b0;
      rise_edge = 1'b0;
      fall_edge = 1'b0;
      base      = 0;
      next_state = state;
      next_state.ctrl_prev = probe_control_word;
      for (int p = 0; p < `DTP_PROBE_COUNT; p++) begin
         base = p * `DTP_PROBE_STRIDE;
         c    = probe_control_word[base +: `DTP_PROBE_STRIDE];
         en   = c[`DTP_C_ENABLE];
         en_rise = en && !state.ctrl_prev[base + `DTP_C_ENABLE];
         // Two-flop synchronisers; only the second stage is read
         next_state.probe[p].sync_a = {state.probe[p].sync_a[0], dig_in[p]};
         next_state.probe[p].sync_b = {state.probe[p].sync_b[0], encoder_index};
         sig = c[`DTP_C_SOURCE] ? state.probe[p].sync_b[1] : state.probe[p].sync_a[1];
         next_state.probe[p].prev = sig;
         // Edge detect on the previous source sample; a source switch may fake one edge
         rise_edge = sig && !state.probe[p].prev;
         fall_edge = !sig && state.probe[p].prev;
         if (en_rise) begin
            next_state.probe[p].rise_armed = 1'b1;
            next_state.probe[p].fall_armed = 1'b1;
         end
         if (en && c[`DTP_C_RISE_EN] && rise_edge && state.probe[p].rise_armed) begin
            next_state.cap[p].rise = position_command;
            next_state.probe[p].rise_done = 1'b1;
            if (!c[`DTP_C_CONTINUOUS]) begin
               next_state.probe[p].rise_armed = 1'b0;
            end
         end
         if (en && c[`DTP_C_FALL_EN] && !c[`DTP_C_SOURCE] && fall_edge
             && state.probe[p].fall_armed) begin
            next_state.cap[p].fall = position_command;
            next_state.probe[p].fall_done = 1'b1;
            if (!c[`DTP_C_CONTINUOUS]) begin
               next_state.probe[p].fall_armed = 1'b0;
            end
         end
         if (!en) begin
            next_state.probe[p].rise_done  = 1'b0;
            next_state.probe[p].fall_done  = 1'b0;
            next_state.probe[p].rise_armed = 1'b0;
            next_state.probe[p].fall_armed = 1'b0;
         end
         next_state.status[base +: `DTP_PROBE_STRIDE] = '0;
         next_state.status[base + `DTP_S_ENABLED]   = en;
         next_state.status[base + `DTP_S_RISE_DONE] = next_state.probe[p].rise_done;
         next_state.status[base + `DTP_S_FALL_DONE] = next_state.probe[p].fall_done;
         // Layout zero adds source and level
         if (!probe_layout_select) begin
            next_state.status[base + `DTP_S_SOURCE] = c[`DTP_C_SOURCE];
            next_state.status[base + `DTP_S_LEVEL]  = state.probe[p].sync_a[1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state           <= '0;
         state.ctrl_prev <= `DTP_CTRL_RESET;
         state.status    <= `DTP_STAT_RESET;
         state.cap[0]    <= {`DTP_POS_RESET, `DTP_POS_RESET};
         state.cap[1]    <= {`DTP_POS_RESET, `DTP_POS_RESET};
      end else begin
         state <= next_state;
      end
   end

   assign probe_status_word      = state.status;
   assign probe_one_rise_capture = state.cap[0].rise;
   assign probe_one_fall_capture = state.cap[0].fall;
   assign probe_two_rise_capture = state.cap[1].rise;
   assign probe_two_fall_capture = state.cap[1].fall;

endmodule

//--- sim/dtp_pins.sv
// Probe-side model: digital inputs four, five and index pulse.
// Assumes the bench sets wanted levels; pins move on falling edges.
`timescale 1ns/1ps
module dtp_pins (
   input  wire logic       clk,
   input  wire logic [2:0] want,
   output logic      [2:0] pins
);
   // Off the sampling edge, as an async source would be
   initial pins = 3'h0;
   always @(negedge clk) pins <= want;
endmodule

//--- sim/dtp_probe_checker.sv
// Port checker for the probe latch.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module dtp_probe_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [15:0] probe_control_word,
   input wire logic        probe_layout_select,
   input wire logic [31:0] position_command,
   input wire logic [15:0] probe_status_word,
   input wire logic [31:0] probe_one_rise_capture,
   input wire logic [31:0] probe_two_rise_capture
);
   wire logic [15:0] c = probe_control_word;
   wire logic [15:0] s = probe_status_word;
   wire logic [31:0] r1 = probe_one_rise_capture;
   wire logic [31:0] r2 = probe_two_rise_capture;
   wire logic [31:0] pc = position_command;
   wire logic        ls = probe_layout_select;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_arm;
      $rose(c[0]);
   endsequence
   a_enable_echo: assert property (s_arm |-> ##[1:2] s[0])
      else $error("enable flag late");
   a_clear_done: assert property (!c[0] |=> s[2:1] == 2'h0)
      else $error("done flags kept");
   a_rise_gate: assert property ($rose(s[1]) |-> $past(c[0]) && $past(c[4]))
      else $error("rise capture unarmed");
   a_index_fall: assert property ($rose(s[10]) |-> !$past(c[10]))
      else $error("fall capture on index");
   a_rise_value: assert property ($rose(s[1]) |-> r1 == $past(pc))
      else $error("probe one value");
   a_two_value: assert property ($rose(s[9]) |-> r2 == $past(pc))
      else $error("probe two value");
   a_layout_zero: assert property ($past(ls) |-> {s[15:14], s[7:6]} == 4'h0)
      else $error("layout bits set");
   a_single_hold: assert property ($past(s[1]) && !$past(c[1]) && s[1] |-> $stable(r1))
      else $error("single mode recaptured");
endmodule
bind dtp_probe_latch dtp_probe_checker dtp_probe_checker_inst (.*);

//--- sim/dual_touch_probe_latch_bench.sv
// Bench: scripted probe edges, queued expectations.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
module dual_touch_probe_latch_bench;
   typedef struct packed {logic [2:0] k; logic [31:0] v;} dtp_note_s;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        lay = 1'b0;
   logic [15:0] ctrl = 16'h0000;
   logic [15:0] st;
   logic [2:0]  want = 3'h0;
   logic [2:0]  pins;
   logic [31:0] pos = 32'h0000_0000;
   logic [31:0] seed = 32'h460a_88e2;
   logic [31:0] p, c1r, c1f, c2r, c2f;
   int          err_count = 0;
   int          n_compared = 0;
   int          cyc = 0;
   dtp_note_s   q [$];
   dtp_note_s   n;
   event        chk;
   dtp_pins dtp_pins_inst (.clk(clk), .want(want), .pins(pins));
   dtp_probe_latch dtp_probe_latch_inst (.clk(clk), .rst(rst), .probe_control_word(ctrl),
      .probe_layout_select(lay), .digital_input_four(pins[0]), .digital_input_five(pins[1]),
      .encoder_index(pins[2]), .position_command(pos), .probe_status_word(st),
      .probe_one_rise_capture(c1r), .probe_one_fall_capture(c1f),
      .probe_two_rise_capture(c2r), .probe_two_fall_capture(c2f));
   initial forever #25 clk = ~clk;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH item %0d expected %h seen %h", n.k, e, g);
      end
   endtask
   task automatic note(input logic [2:0] k, input logic [31:0] v);
      q.push_back('{k, v});
      ->chk;
   endtask
   // Edge, then room for the two-flop sync and capture
   task automatic step(input logic [2:0] w);
      want = w;
      repeat (6) @(negedge clk);
   endtask
   task print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(chk) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         cmp(n.v, n.k == 3'h0 ? {16'h0000, st} : n.k == 3'h1 ? c1r : n.k == 3'h2 ? c1f
             : n.k == 3'h3 ? c2r : c2f);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         err_count++;
         print_verdict();
      end
   end
   // never both edge enable bits set on one probe
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      note(0, 32'h0000);
      ctrl = 16'h0011; p = xs(); pos = p; step(3'h1);
      note(0, 32'h0083); note(1, p);
      pos = xs(); step(3'h0); step(3'h1); note(1, p);
      ctrl = 16'h0000; step(3'h0); note(0, 32'h0000); note(2, 0);
      ctrl = 16'h0021; step(3'h1); note(0, 32'h0081);
      p = xs(); pos = p; step(3'h0); note(2, p); note(0, 32'h0005);
      lay = 1'b1; ctrl = 16'h1700; p = xs(); pos = p; step(3'h4); note(3, p);
      p = xs(); pos = p; step(3'h0); step(3'h4); note(3, p);
      note(0, 32'h0300);
      ctrl = 16'h2500; step(3'h0); note(4, 0); note(0, 32'h0300);
      lay = 1'b0; step(3'h0); note(0, 32'h4300);
      print_verdict();
   end
endmodule
